// File: rtl/bsid_defs.svh
/*
 * Constants of the boundary scan instruction decode block: opcodes, widths,
 * capture patterns and the synchroniser depth.
 * Assumes nothing; guarded, so the package and other files may all include it.
 */
// Behaviour
// - Instruction shift register takes test data input on rising test clock in Shift-IR.
// - Shifted opcode becomes current only at Update-IR; older opcode stays until then.
// - Instruction register is six bits and all six are decoded.
// - Opcode 000000 drives pins and enables from boundary output latches.
// - Opcode 000001 snapshots pins, core and enables; updates latches, pins untouched.
// - Opcode 000010 puts the 32-bit identification register on the serial path.
// - Opcode 000011 forces every boundary-controlled output to high impedance.
// - Capture-IR loads pattern 101101, so the two low bits shift out 01.
// - Opcodes 111100 and 111101 select boundary register for AC pin tests.
// - Opcode 111110 keeps pins on boundary latches with bypass on serial path.
// - Opcode 111111 makes the serial path one register stage.
// - Bypass register loads zero at Capture-DR when selected.
// - Under opcode 000000 Update-DR moves shifted values to pins and enables.
// - Current opcode picks the single data register between input and output.
// - Unselected data registers leave chip operation and selected register undisturbed.
// - Test reset, by pin or five high mode clocks, makes identification current.
// - Identification register is 32 bits with least significant bit fixed at one.
// - Boundary path uses a falling-edge stage so clock skew cannot corrupt data.
`ifndef BSID_DEFS_SVH
`define BSID_DEFS_SVH

`define BSID_IR_W 6
`define BSID_OP_EXT_DRIVE 6'h00
`define BSID_OP_SAMPLE_LOAD 6'h01
`define BSID_OP_ID_READ 6'h02
`define BSID_OP_FLOAT 6'h03
`define BSID_OP_AC_TRAIN 6'h3C
`define BSID_OP_AC_PULSE 6'h3D
`define BSID_OP_HOLD_PINS 6'h3E
`define BSID_OP_ONE_BIT 6'h3F
`define BSID_CAPTURE_IR_DEFAULT_PATTERN 6'h2D
`define BSID_ID_W 32
`define BSID_ID_LSB 1'h1
`define BSID_BYP_CAPTURE 1'h0
`define BSID_SYNC_STAGES 2

`endif

// File: rtl/bsid_pkg.sv
/*
 * Types of the boundary scan instruction decode block.
 * Assumes bsid_defs.svh is on the include path.
 */
`include "bsid_defs.svh"

package bsid_pkg;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } bsid_tap_e;

    typedef enum logic [1:0] {DR_BOUNDARY, DR_ONE_BIT, DR_IDENT} bsid_dr_e;

    typedef enum logic [1:0] {PM_FUNCTIONAL, PM_TEST, PM_FLOAT} bsid_pin_e;

    typedef struct packed {
        bsid_dr_e dr;
        bsid_pin_e pins;
        logic ac;
    } bsid_decode_s;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } bsid_jtag_s;

endpackage

// File: rtl/bsid_tap_fsm.sv
/*
 * Test access port controller: sixteen states, stepped once per rising
 * test clock edge as found by the caller.
 * Assumes step and tms are already in the clk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module bsid_tap_fsm
    import bsid_pkg::*;
(
    // Clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tap_reset,
    // Stepping
    input wire logic step,
    input wire logic tms,
    // State
    output bsid_tap_e state
);

    bsid_tap_e next_state;

    always_comb begin
        next_state = state;
        case (state)
            TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_state = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_state = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_state = tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_state = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_state = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
            default: next_state = TAP_RESET;
        endcase
    end

    // Five high mode clocks reach TAP_RESET from any state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TAP_RESET;
        end else if (tap_reset) begin
            state <= TAP_RESET;
        end else if (step) begin
            state <= next_state;
        end
    end

    tap_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        tap_reset |=> state == TAP_RESET)
        else $error("test reset did not reach reset state");

endmodule

`default_nettype wire

// File: rtl/bsid_top.sv
/*
 * Instruction register, decoder and data register paths of the test port,
 * with the boundary cells' output latches and pin steering.
 * Assumes the test pins are asynchronous to clk and far slower than it;
 * core signals are on clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bsid_defs.svh"

module bsid_top
    import bsid_pkg::*;
#(
    parameter int NPIN = 8,
    parameter logic [3:0] ID_VERSION = 4'h1,  // Arbitrary value
    parameter logic [15:0] ID_PART = 16'h1234, // Arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h055  // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Test port pins
    input wire bsid_jtag_s jtag,
    output logic tdo,
    output logic tdo_oe,
    // Core side of the boundary pins
    input wire logic [NPIN-1:0] core_out,
    input wire logic [NPIN-1:0] core_oe,
    // Pad side of the boundary pins
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe,
    // Test status
    output logic ac_active
);

    localparam int BSR_W = 3 * NPIN;

    function automatic bsid_decode_s decode(input logic [`BSID_IR_W-1:0] op);
        bsid_decode_s d;
        d = '{dr: DR_ONE_BIT, pins: PM_FUNCTIONAL, ac: 1'b0};
        case (op)
            `BSID_OP_EXT_DRIVE: d = '{dr: DR_BOUNDARY, pins: PM_TEST, ac: 1'b0};
            `BSID_OP_SAMPLE_LOAD: d = '{dr: DR_BOUNDARY, pins: PM_FUNCTIONAL, ac: 1'b0};
            `BSID_OP_ID_READ: d = '{dr: DR_IDENT, pins: PM_FUNCTIONAL, ac: 1'b0};
            `BSID_OP_FLOAT: d = '{dr: DR_ONE_BIT, pins: PM_FLOAT, ac: 1'b0};
            `BSID_OP_AC_TRAIN: d = '{dr: DR_BOUNDARY, pins: PM_TEST, ac: 1'b1};
            `BSID_OP_AC_PULSE: d = '{dr: DR_BOUNDARY, pins: PM_TEST, ac: 1'b1};
            `BSID_OP_HOLD_PINS: d = '{dr: DR_ONE_BIT, pins: PM_TEST, ac: 1'b0};
            `BSID_OP_ONE_BIT: d = '{dr: DR_ONE_BIT, pins: PM_FUNCTIONAL, ac: 1'b0};
            default: d = '{dr: DR_ONE_BIT, pins: PM_FUNCTIONAL, ac: 1'b0};
        endcase
        return d;
    endfunction

    logic rst_s1;
    logic rst_sync_n;
    bsid_jtag_s jtag_s1;
    bsid_jtag_s jtag_s2;
    logic tck_d;
    logic tck_rise;
    logic tck_fall;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    bsid_tap_e state;
    logic [`BSID_IR_W-1:0] ir_shift;
    logic [`BSID_IR_W-1:0] ir_cur;
    bsid_decode_s dec;
    logic byp;
    logic [`BSID_ID_W-1:0] idr;
    logic [BSR_W-1:0] bsr;
    logic [BSR_W-1:0] bsr_capture;
    logic [NPIN-1:0] upd_out;
    logic [NPIN-1:0] upd_oe;
    logic dr_serial;
    logic in_shift;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_sync_n <= rst_s1;
        end
    end

    // Test pins and pads are asynchronous; same depth keeps them aligned to tck
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            jtag_s1 <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
            jtag_s2 <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
            tck_d <= 1'b0;
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            jtag_s1 <= jtag;
            jtag_s2 <= jtag_s1;
            tck_d <= jtag_s2.tck;
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
        end
    end

    assign tck_rise = jtag_s2.tck & ~tck_d;
    assign tck_fall = ~jtag_s2.tck & tck_d;

    bsid_tap_fsm u_fsm (
        .clk(clk),
        .rst_n(rst_sync_n),
        .tap_reset(~jtag_s2.trst_n),
        .step(tck_rise),
        .tms(jtag_s2.tms),
        .state(state)
    );

    // Instruction shift register
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ir_shift <= `BSID_CAPTURE_IR_DEFAULT_PATTERN;
        end else if (tck_rise && state == TAP_CAP_IR) begin
            ir_shift <= `BSID_CAPTURE_IR_DEFAULT_PATTERN;
        end else if (tck_rise && state == TAP_SHIFT_IR) begin
            ir_shift <= {jtag_s2.tdi, ir_shift[`BSID_IR_W-1:1]};
        end
    end

    // Current instruction; takes effect on the falling edge in Update-IR
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ir_cur <= `BSID_OP_ID_READ;
        end else if (state == TAP_RESET) begin
            ir_cur <= `BSID_OP_ID_READ;
        end else if (tck_fall && state == TAP_UPD_IR) begin
            ir_cur <= ir_shift;
        end
    end

    always_comb begin
        dec = decode(ir_cur);
    end

    // Bypass stage: only moves when it is the selected register
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            byp <= `BSID_BYP_CAPTURE;
        end else if (tck_rise && dec.dr == DR_ONE_BIT) begin
            if (state == TAP_CAP_DR) begin
                byp <= `BSID_BYP_CAPTURE;
            end else if (state == TAP_SHIFT_DR) begin
                byp <= jtag_s2.tdi;
            end
        end
    end

    // Identification register
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            idr <= '0;
        end else if (tck_rise && dec.dr == DR_IDENT) begin
            if (state == TAP_CAP_DR) begin
                idr <= {ID_VERSION, ID_PART, ID_MAKER, `BSID_ID_LSB};
            end else if (state == TAP_SHIFT_DR) begin
                idr <= {jtag_s2.tdi, idr[`BSID_ID_W-1:1]};
            end
        end
    end

    // Cell triplet per pin: pad observe, output data, output enable
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_cell
            assign bsr_capture[3*gi] = pin_s2[gi];
            assign bsr_capture[3*gi+1] = core_out[gi];
            assign bsr_capture[3*gi+2] = core_oe[gi];
        end
    endgenerate

    // Boundary shift register
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bsr <= '0;
        end else if (tck_rise && dec.dr == DR_BOUNDARY) begin
            if (state == TAP_CAP_DR) begin
                bsr <= bsr_capture;
            end else if (state == TAP_SHIFT_DR) begin
                bsr <= {jtag_s2.tdi, bsr[BSR_W-1:1]};
            end
        end
    end

    // Output latches load on the falling edge, away from the shifting edge
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_upd
            always_ff @(posedge clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    upd_out[gi] <= 1'b0;
                    upd_oe[gi] <= 1'b0;
                end else if (tck_fall && state == TAP_UPD_DR && dec.dr == DR_BOUNDARY) begin
                    upd_out[gi] <= bsr[3*gi+1];
                    upd_oe[gi] <= bsr[3*gi+2];
                end
            end
        end
    endgenerate

    // Pin steering; latched state reaches pins only in test modes
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            case (dec.pins)
                PM_TEST: begin
                    pin_out <= upd_out;
                    pin_oe <= upd_oe;
                end
                PM_FLOAT: begin
                    pin_out <= core_out;
                    pin_oe <= '0;
                end
                default: begin
                    pin_out <= core_out;
                    pin_oe <= core_oe;
                end
            endcase
        end
    end

    // AC tests pulse for as long as the controller idles
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ac_active <= 1'b0;
        end else begin
            ac_active <= dec.ac && state == TAP_IDLE;
        end
    end

    // Serial output mux and falling-edge output stage
    always_comb begin
        case (dec.dr)
            DR_BOUNDARY: dr_serial = bsr[0];
            DR_IDENT: dr_serial = idr[0];
            default: dr_serial = byp;
        endcase
    end

    assign in_shift = state == TAP_SHIFT_IR || state == TAP_SHIFT_DR;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo <= (state == TAP_SHIFT_IR) ? ir_shift[0] : dr_serial;
            tdo_oe <= in_shift;
        end
    end

    ir_capture_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        tck_rise && state == TAP_CAP_IR |=> ir_shift == `BSID_CAPTURE_IR_DEFAULT_PATTERN)
        else $error("capture pattern not loaded");

    ir_shift_in_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        tck_rise && state == TAP_SHIFT_IR |=> ir_shift[`BSID_IR_W-1] == $past(jtag_s2.tdi))
        else $error("instruction bit not taken");

    ir_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        !$stable(ir_cur) |-> $past(state) == TAP_UPD_IR || $past(state) == TAP_RESET)
        else $error("instruction changed outside update");

    reset_ident_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        state == TAP_RESET |=> ir_cur == `BSID_OP_ID_READ)
        else $error("reset did not select identification");

    byp_zero_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        tck_rise && state == TAP_CAP_DR && dec.dr == DR_ONE_BIT |=> byp == 1'b0)
        else $error("bypass not cleared at capture");

    byp_quiet_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        dec.dr != DR_ONE_BIT |=> $stable(byp))
        else $error("unselected bypass moved");

    id_lsb_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        tck_rise && state == TAP_CAP_DR && dec.dr == DR_IDENT |=> idr[0] == 1'b1)
        else $error("identification lsb not one");

    float_pins_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        dec.pins == PM_FLOAT ##1 dec.pins == PM_FLOAT |-> pin_oe == '0)
        else $error("pins driven while floating");

    ext_drive_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        dec.pins == PM_TEST |=> pin_out == $past(upd_out) && pin_oe == $past(upd_oe))
        else $error("pins not on output latches");

    tdo_enable_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        tck_fall |=> tdo_oe == $past(in_shift) ##1 $stable(tdo) || $past(tck_fall))
        else $error("serial output enable wrong");

endmodule

`default_nettype wire

// File: test/bsid_tester.sv
/*
 * Board tester model: drives test clock, mode select, data in and test reset.
 * Assumes the bench clk at 4 ns; one test clock period is 12 clk (48 ns).
 */
`timescale 1ns/1ps
`default_nettype none

module bsid_tester
    import bsid_pkg::*;
(
    // Clock
    input wire logic clk,
    // Test port
    output var bsid_jtag_s jtag,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // Clock parked low; data and mode lines rest on their pull-ups
    initial begin
        jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
    end

    // One period: mode and data change with the fall, held across the rise
    task automatic tick(input logic m, input logic d, output logic o);
        @(posedge clk);
        jtag.tck <= 1'b0;
        jtag.tms <= m;
        jtag.tdi <= d;
        repeat (5) @(posedge clk);
        // Undriven output reads inverted, so a missing enable spoils the bit
        o = tdo_oe ? tdo : ~tdo;
        @(posedge clk);
        jtag.tck <= 1'b1;
        repeat (5) @(posedge clk);
    endtask

    // From Run-Test/Idle through one scan, LSB first, back to Run-Test/Idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b1, o);
        if (ir) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask

    // Five high mode clocks, then into Run-Test/Idle
    task automatic reset_tap;
        logic o;
        repeat (5) tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
    endtask

    // Test reset pin pulse; long enough to pass the synchronisers
    task automatic pulse_trst;
        logic o;
        @(posedge clk);
        jtag.trst_n <= 1'b0;
        repeat (8) @(posedge clk);
        jtag.trst_n <= 1'b1;
        repeat (6) @(posedge clk);
        tick(1'b0, 1'b1, o);
    endtask
endmodule

`default_nettype wire

// File: test/boundary_scan_instruction_decode_bench.sv
/*
 * Self-checking bench of the instruction register and decoder.
 * Assumes bsid_pkg and the tester model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bsid_defs.svh"

module boundary_scan_instruction_decode_bench
    import bsid_pkg::*;
;
    localparam int NP = 8;
    localparam logic [3:0] VER = 4'h6; // Arbitrary value
    localparam logic [15:0] PART = 16'h4D2A; // Arbitrary value
    localparam logic [10:0] MAKER = 11'h1B7; // Arbitrary value
    localparam logic [31:0] ID_WORD = {VER, PART, MAKER, `BSID_ID_LSB};

    typedef struct packed {
        logic [5:0] op;
        bsid_dr_e dr;
        bsid_pin_e pins;
        logic ac;
    } bsid_row_s;

    // Preload first so the external test never drives stale latches
    bsid_row_s rows [10] = '{
        '{`BSID_OP_SAMPLE_LOAD, DR_BOUNDARY, PM_FUNCTIONAL, 1'b0},
        '{`BSID_OP_EXT_DRIVE, DR_BOUNDARY, PM_TEST, 1'b0},
        '{`BSID_OP_AC_TRAIN, DR_BOUNDARY, PM_TEST, 1'b1},
        '{`BSID_OP_AC_PULSE, DR_BOUNDARY, PM_TEST, 1'b1},
        '{`BSID_OP_HOLD_PINS, DR_ONE_BIT, PM_TEST, 1'b0},
        '{`BSID_OP_FLOAT, DR_ONE_BIT, PM_FLOAT, 1'b0},
        '{`BSID_OP_ID_READ, DR_IDENT, PM_FUNCTIONAL, 1'b0},
        '{`BSID_OP_ONE_BIT, DR_ONE_BIT, PM_FUNCTIONAL, 1'b0},
        '{6'h15, DR_ONE_BIT, PM_FUNCTIONAL, 1'b0},
        '{6'h3B, DR_ONE_BIT, PM_FUNCTIONAL, 1'b0}
    };

    logic clk;
    logic rst_n;
    bsid_jtag_s jtag;
    logic tdo;
    logic tdo_oe;
    logic [NP-1:0] core_out;
    logic [NP-1:0] core_oe;
    logic [NP-1:0] pin_in;
    logic [NP-1:0] pin_out;
    logic [NP-1:0] pin_oe;
    logic ac_active;
    logic [NP-1:0] lat_out;
    logic [NP-1:0] lat_oe;
    int n_fail = 0;
    int checks_done = 0;

    bsid_top #(.NPIN(NP), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) dut (
        .clk(clk), .rst_n(rst_n), .jtag(jtag), .tdo(tdo), .tdo_oe(tdo_oe),
        .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .ac_active(ac_active)
    );

    bsid_tester tester (.clk(clk), .jtag(jtag), .tdo(tdo), .tdo_oe(tdo_oe));

    initial begin
        clk = 1'b0;
    end
    always #2 clk = ~clk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_pins(input bsid_pin_e pm);
        logic [15:0] e;
        repeat (3) @(posedge clk);
        case (pm)
            PM_TEST: e = {lat_oe, lat_out};
            PM_FLOAT: e = {8'h00, core_out};
            default: e = {core_oe, core_out};
        endcase
        chk("pins", {16'h0, e}, {16'h0, pin_oe, pin_out});
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard: every wait is a fixed count, this bounds the whole run
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        close_out();
    end

    initial begin
        logic [31:0] din;
        logic [31:0] dout;
        logic [31:0] exp;
        logic [31:0] mask;
        rst_n = 1'b0;
        core_out = 8'h5A;
        core_oe = 8'hC3;
        pin_in = 8'h0F;
        repeat (12) @(posedge clk);
        chk("oe in reset", 32'h0, {23'h0, tdo_oe, pin_oe});
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        check_pins(PM_FUNCTIONAL);
        // Controller rests in its reset state; scans start from idle
        tester.reset_tap();
        tester.scan(1'b0, 32, 32'h0, dout);
        chk("id after reset", ID_WORD, dout);
        foreach (rows[r]) begin
            core_out <= 8'h96 ^ {2'h0, rows[r].op};
            core_oe <= 8'h3C + {2'h0, rows[r].op};
            pin_in <= 8'hE1 ^ {rows[r].op, 2'h0};
            tester.scan(1'b1, 6, {26'h0, rows[r].op}, dout);
            chk("ir capture", {26'h0, `BSID_CAPTURE_IR_DEFAULT_PATTERN}, dout);
            check_pins(rows[r].pins);
            din = 32'h9E37_79B9 ^ {26'h0, rows[r].op};
            tester.scan(1'b0, 32, din, dout);
            mask = 32'hFFFF_FFFF;
            case (rows[r].dr)
                DR_ONE_BIT: exp = {din[30:0], `BSID_BYP_CAPTURE};
                DR_IDENT: exp = ID_WORD;
                default: begin
                    exp = {din[7:0], 24'h0};
                    for (int i = 0; i < NP; i++) begin
                        exp[3*i] = pin_in[i];
                        exp[3*i+1] = core_out[i];
                        exp[3*i+2] = core_oe[i];
                        lat_out[i] = din[3*i+9];
                        lat_oe[i] = din[3*i+10];
                    end
                    // Only the pad observe cells have a defined capture outside sampling
                    if (rows[r].op != `BSID_OP_SAMPLE_LOAD) begin
                        mask = 32'hFF24_9249;
                    end
                end
            endcase
            chk("dr path", exp & mask, dout & mask);
            check_pins(rows[r].pins);
            chk("ac flag", {31'h0, rows[r].ac}, {31'h0, ac_active});
            chk("tdo idle", 32'h0, {31'h0, tdo_oe});
        end
        tester.scan(1'b1, 6, {26'h0, `BSID_OP_ONE_BIT}, dout);
        tester.reset_tap();
        tester.scan(1'b0, 32, 32'h0, dout);
        chk("id after mode reset", ID_WORD, dout);
        tester.scan(1'b1, 6, {26'h0, `BSID_OP_EXT_DRIVE}, dout);
        check_pins(PM_TEST);
        tester.pulse_trst();
        check_pins(PM_FUNCTIONAL);
        tester.scan(1'b0, 32, 32'h0, dout);
        chk("id after pin reset", ID_WORD, dout);
        close_out();
    end
endmodule

`default_nettype wire
